// [hdl/icap_pkg.sv]
// package for the input capture channel: register map, field positions,
// reset values, mode codes and the structs carried by the top-level ports.
// assumes a 50 MHz single clock and a 32-bit Avalon-MM register master.

package icap_pkg;

    // register byte offsets
    localparam logic [3:0] ICAP_OFS_CTRL1 = 4'h0;
    localparam logic [3:0] ICAP_OFS_CTRL2 = 4'h4;
    localparam logic [3:0] ICAP_OFS_DATA = 4'h8;
    localparam logic [3:0] ICAP_OFS_COUNT = 4'hC;

    // field positions, control one
    localparam int ICAP_B_SIDL = 13;
    localparam int ICAP_B_TSEL = 10;
    localparam int ICAP_B_CPI = 5;
    localparam int ICAP_B_OVF = 4;
    localparam int ICAP_B_BNE = 3;
    localparam int ICAP_B_MODE = 0;
    // field positions, control two
    localparam int ICAP_B_CASC = 8;
    localparam int ICAP_B_TRIG = 7;
    localparam int ICAP_B_TSTAT = 6;
    localparam int ICAP_B_SSEL = 0;

    // values after reset
    localparam logic [2:0] ICAP_TSEL_RST = 3'h0;
    localparam logic [4:0] ICAP_SSEL_RST = 5'h0D;
    localparam logic [2:0] ICAP_MODE_RST = 3'h0;
    localparam logic [1:0] ICAP_CPI_RST = 2'h0;

    // capture mode codes
    localparam logic [2:0] ICAP_M_OFF = 3'h0;
    localparam logic [2:0] ICAP_M_EDGE = 3'h1;
    localparam logic [2:0] ICAP_M_FALL = 3'h2;
    localparam logic [2:0] ICAP_M_RISE = 3'h3;
    localparam logic [2:0] ICAP_M_PRE4 = 3'h4;
    localparam logic [2:0] ICAP_M_PRE16 = 3'h5;
    localparam logic [2:0] ICAP_M_UNUSED = 3'h6;
    localparam logic [2:0] ICAP_M_WAKE = 3'h7;

    // prescaler terminal counts
    localparam logic [3:0] ICAP_PRE4_LAST = 4'h3;
    localparam logic [3:0] ICAP_PRE16_LAST = 4'hF;

    // fifo depth
    localparam logic [2:0] ICAP_DEPTH = 3'h4;

    // counter clock select codes
    localparam logic [2:0] ICAP_TS_T3 = 3'h0;
    localparam logic [2:0] ICAP_TS_T2 = 3'h1;
    localparam logic [2:0] ICAP_TS_T4 = 3'h2;
    localparam logic [2:0] ICAP_TS_T5 = 3'h3;
    localparam logic [2:0] ICAP_TS_T1 = 3'h4;
    localparam logic [2:0] ICAP_TS_FP = 3'h7;

    // source select codes that name no source
    localparam logic [4:0] ICAP_SS_NONE_LO = 5'h00;
    localparam logic [4:0] ICAP_SS_NONE_MID = 5'h0A;
    localparam logic [4:0] ICAP_SS_RSVD = 5'h1C;
    localparam logic [4:0] ICAP_SS_NONE_HI = 5'h1D;

    // avalon-mm request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } icap_avs_req_t;

    // avalon-mm answer to the master
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } icap_avs_rsp_t;

    // pin and neighbour inputs
    typedef struct packed {
        logic capture_pin;
        logic cpu_idle;
        logic cpu_sleep;
        logic [4:0] tmr_tick;
        logic casc_carry;
        logic casc_upper;
    } icap_evt_t;

    // event outputs, all one-cycle pulses
    typedef struct packed {
        logic irq;
        logic dma_req;
        logic cap_pulse;
        logic wake_irq;
        logic wrap;
    } icap_out_t;

    // whole channel state
    typedef struct packed {
        logic stop_when_idle;
        logic [2:0] counter_clock_select;
        logic [1:0] captures_per_irq;
        logic [2:0] capture_mode_select;
        logic cascade_enable;
        logic trigger_not_sync_select;
        logic trigger_running_status;
        logic [4:0] sync_source_select;
        logic buffer_overflow_flag;
        logic [15:0] channel_counter;
        logic pin_q;
        logic [3:0] pre;
        logic [1:0] evt;
        logic [3:0][15:0] fifo;
        logic [1:0] rd_ptr;
        logic [1:0] wr_ptr;
        logic [2:0] level;
        icap_avs_rsp_t rsp;
        icap_out_t out;
    } icap_state_t;

endpackage

// [hdl/icap_channel.sv]
// one input capture channel with its avalon-mm register slave.
// assumes all inputs synchronous to clk_i; timer ticks are one-cycle enables.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps

module icap_channel (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register bus
    input wire icap_pkg::icap_avs_req_t avs_i,
    output icap_pkg::icap_avs_rsp_t avs_o,
    // pin, timer ticks, cpu power state, cascade partner
    input wire icap_pkg::icap_evt_t ev_i,
    // trigger or sync events, indexed by source code
    input wire logic [31:0] sync_evt_i,
    // interrupt, dma and neighbour pulses
    output icap_pkg::icap_out_t out_o
);
    import icap_pkg::*;

    // -----------------------------------------------------------------
    // decoding helpers
    // -----------------------------------------------------------------

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = old_v;
        if (be[0])
        begin
            merge16[7:0] = wd[7:0];
        end
        if (be[1])
        begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // channel is in a capturing mode
    function automatic logic mode_active(input logic [2:0] m);
        mode_active = (m != ICAP_M_OFF) && (m != ICAP_M_UNUSED) &&
                      (m != ICAP_M_WAKE);
    endfunction

    // source code names a real source
    function automatic logic src_valid(input logic [4:0] c);
        src_valid = (c != ICAP_SS_NONE_LO) && (c != ICAP_SS_NONE_MID) &&
                    (c != ICAP_SS_RSVD) && (c < ICAP_SS_NONE_HI);
    endfunction

    // -----------------------------------------------------------------
    // state and decoded events
    // -----------------------------------------------------------------

    icap_state_t q_r;
    icap_state_t s_nxt;
    logic active;
    logic run;
    logic rise;
    logic fall;
    logic tick;
    logic sev;
    logic hold;
    logic cap;
    logic acc;
    logic pop;
    logic [15:0] ctrl1_v;
    logic [15:0] ctrl2_v;
    logic [2:0] lvl_pop;

    assign active = mode_active(q_r.capture_mode_select);
    // idle halt freezes both counting and capturing
    assign run = active && !(q_r.stop_when_idle && ev_i.cpu_idle);
    assign rise = ev_i.capture_pin && !q_r.pin_q;
    assign fall = !ev_i.capture_pin && q_r.pin_q;
    assign sev = src_valid(q_r.sync_source_select) &&
                 sync_evt_i[q_r.sync_source_select];
    assign hold = q_r.trigger_not_sync_select &&
                  !q_r.trigger_running_status;
    assign acc = (avs_i.read || avs_i.write) && q_r.rsp.waitrequest;
    assign pop = acc && avs_i.read && (avs_i.address == ICAP_OFS_DATA) &&
                 (q_r.level != 3'h0);
    assign lvl_pop = pop ? q_r.level - 3'h1 : q_r.level;

    // counter clock: upper half of a cascade counts the partner's wrap
    always_comb
    begin
        if (q_r.cascade_enable && ev_i.casc_upper)
        begin
            tick = ev_i.casc_carry;
        end
        else
        begin
            unique case (q_r.counter_clock_select)
                ICAP_TS_T3: tick = ev_i.tmr_tick[2];
                ICAP_TS_T2: tick = ev_i.tmr_tick[1];
                ICAP_TS_T4: tick = ev_i.tmr_tick[3];
                ICAP_TS_T5: tick = ev_i.tmr_tick[4];
                ICAP_TS_T1: tick = ev_i.tmr_tick[0];
                ICAP_TS_FP: tick = 1'b1;
                default: tick = 1'b0; // reserved codes stop the counter
            endcase
        end
    end

    // qualifying capture edge for the current mode
    always_comb
    begin
        cap = 1'b0;
        if (run)
        begin
            unique case (q_r.capture_mode_select)
                ICAP_M_EDGE: cap = rise || fall;
                ICAP_M_FALL: cap = fall;
                ICAP_M_RISE: cap = rise;
                ICAP_M_PRE4: cap = rise && (q_r.pre == ICAP_PRE4_LAST);
                ICAP_M_PRE16: cap = rise && (q_r.pre == ICAP_PRE16_LAST);
                default: cap = 1'b0; // off, unused and wake modes
            endcase
        end
    end

    // readable images of the two control registers
    always_comb
    begin
        ctrl1_v = 16'h0000;
        ctrl1_v[ICAP_B_SIDL] = q_r.stop_when_idle;
        ctrl1_v[ICAP_B_TSEL +: 3] = q_r.counter_clock_select;
        ctrl1_v[ICAP_B_CPI +: 2] = q_r.captures_per_irq;
        ctrl1_v[ICAP_B_OVF] = q_r.buffer_overflow_flag;
        ctrl1_v[ICAP_B_BNE] = (q_r.level != 3'h0);
        ctrl1_v[ICAP_B_MODE +: 3] = q_r.capture_mode_select;
        ctrl2_v = 16'h0000;
        ctrl2_v[ICAP_B_CASC] = q_r.cascade_enable;
        ctrl2_v[ICAP_B_TRIG] = q_r.trigger_not_sync_select;
        ctrl2_v[ICAP_B_TSTAT] = q_r.trigger_running_status;
        ctrl2_v[ICAP_B_SSEL +: 5] = q_r.sync_source_select;
    end

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------

    // bus access first, hardware events after, so a hardware set wins
    always_comb
    begin
        logic [15:0] w1;
        logic [15:0] w2;
        w1 = merge16(ctrl1_v, avs_i.writedata, avs_i.byteenable);
        w2 = merge16(ctrl2_v, avs_i.writedata, avs_i.byteenable);
        s_nxt = q_r;
        s_nxt.out = '0;
        s_nxt.rsp.waitrequest = 1'b1;
        s_nxt.pin_q = ev_i.capture_pin;

        // one wait cycle, then a single answer cycle
        if (acc)
        begin
            s_nxt.rsp.waitrequest = 1'b0;
            s_nxt.rsp.readdata = 32'h0000_0000;
            if (avs_i.read)
            begin
                unique case (avs_i.address)
                    ICAP_OFS_CTRL1: s_nxt.rsp.readdata[15:0] = ctrl1_v;
                    ICAP_OFS_CTRL2: s_nxt.rsp.readdata[15:0] = ctrl2_v;
                    ICAP_OFS_DATA: s_nxt.rsp.readdata[15:0] =
                        pop ? q_r.fifo[q_r.rd_ptr] : 16'h0000;
                    ICAP_OFS_COUNT: s_nxt.rsp.readdata[15:0] =
                        q_r.channel_counter;
                    default: s_nxt.rsp.readdata = 32'h0000_0000;
                endcase
            end
        end

        // a write lands only at the edge that completes it, waitrequest low
        if (avs_i.write && !q_r.rsp.waitrequest)
        begin
            if (avs_i.address == ICAP_OFS_CTRL1)
            begin
                // overflow and not-empty are read-only
                s_nxt.stop_when_idle = w1[ICAP_B_SIDL];
                s_nxt.counter_clock_select = w1[ICAP_B_TSEL +: 3];
                s_nxt.captures_per_irq = w1[ICAP_B_CPI +: 2];
                s_nxt.capture_mode_select = w1[ICAP_B_MODE +: 3];
            end
            else if (avs_i.address == ICAP_OFS_CTRL2)
            begin
                s_nxt.cascade_enable = w2[ICAP_B_CASC];
                s_nxt.trigger_not_sync_select = w2[ICAP_B_TRIG];
                s_nxt.trigger_running_status = w2[ICAP_B_TSTAT];
                s_nxt.sync_source_select = w2[ICAP_B_SSEL +: 5];
            end
        end

        // pop the oldest entry; draining the fifo clears the overflow
        if (pop)
        begin
            s_nxt.rd_ptr = q_r.rd_ptr + 2'h1;
            if (lvl_pop == 3'h0)
            begin
                s_nxt.buffer_overflow_flag = 1'b0;
            end
        end
        s_nxt.level = lvl_pop;

        // trigger source sets the status, winning over a software clear
        if (q_r.trigger_not_sync_select && sev)
        begin
            s_nxt.trigger_running_status = 1'b1;
        end

        // counter: held clear until triggered, reset by a sync event
        if (!active || hold)
        begin
            s_nxt.channel_counter = 16'h0000;
        end
        else if (run && !q_r.trigger_not_sync_select && sev)
        begin
            s_nxt.channel_counter = 16'h0000;
        end
        else if (run && tick)
        begin
            s_nxt.channel_counter = q_r.channel_counter + 16'h0001;
            s_nxt.out.wrap = (q_r.channel_counter == 16'hFFFF);
        end

        // prescaler counts rising edges in the divided modes
        if (run && rise && (q_r.capture_mode_select == ICAP_M_PRE4))
        begin
            s_nxt.pre = (q_r.pre == ICAP_PRE4_LAST) ? 4'h0 : q_r.pre + 4'h1;
        end
        else if (run && rise && (q_r.capture_mode_select == ICAP_M_PRE16))
        begin
            s_nxt.pre = q_r.pre + 4'h1; // wraps after sixteen edges
        end

        // capture: push if room, otherwise flag overflow and keep entries
        if (cap)
        begin
            s_nxt.out.cap_pulse = 1'b1;
            s_nxt.out.dma_req = 1'b1;
            if (lvl_pop < ICAP_DEPTH)
            begin
                s_nxt.fifo[q_r.wr_ptr] = q_r.channel_counter;
                s_nxt.wr_ptr = q_r.wr_ptr + 2'h1;
                s_nxt.level = lvl_pop + 3'h1;
            end
            else
            begin
                s_nxt.buffer_overflow_flag = 1'b1;
            end
            // every-edge mode ignores the per-interrupt count
            if (q_r.capture_mode_select == ICAP_M_EDGE)
            begin
                s_nxt.out.irq = 1'b1;
            end
            else if (q_r.evt == q_r.captures_per_irq)
            begin
                s_nxt.out.irq = 1'b1;
                s_nxt.evt = 2'h0;
            end
            else
            begin
                s_nxt.evt = q_r.evt + 2'h1;
            end
        end

        // wake mode: only a rising edge while the cpu sleeps or idles
        if ((q_r.capture_mode_select == ICAP_M_WAKE) && rise &&
            (ev_i.cpu_idle || ev_i.cpu_sleep))
        begin
            s_nxt.out.irq = 1'b1;
            s_nxt.out.wake_irq = 1'b1;
        end

        // switched off: flush the fifo and its flags
        if (!active)
        begin
            s_nxt.level = 3'h0;
            s_nxt.rd_ptr = 2'h0;
            s_nxt.wr_ptr = 2'h0;
            s_nxt.buffer_overflow_flag = 1'b0;
            s_nxt.pre = 4'h0;
            s_nxt.evt = 2'h0;
        end
    end

    // state register; reset clears every field but waitrequest (set) and the source select (ICAP_SSEL_RST), fifo words included
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            q_r <= '0;
            q_r.rsp.waitrequest <= 1'b1;
            q_r.counter_clock_select <= ICAP_TSEL_RST;
            q_r.sync_source_select <= ICAP_SSEL_RST;
            q_r.capture_mode_select <= ICAP_MODE_RST;
            q_r.captures_per_irq <= ICAP_CPI_RST;
        end
        else
        begin
            q_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign avs_o = q_r.rsp;
    assign out_o = q_r.out;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_room_cap;
        cap && !pop && (q_r.level < ICAP_DEPTH);
    endsequence

    sequence s_full_cap;
        cap && !pop && (q_r.level == ICAP_DEPTH);
    endsequence

    a_prescale_edges: assert property (
        (run && rise && (q_r.capture_mode_select == ICAP_M_PRE4) &&
         (q_r.pre != ICAP_PRE4_LAST)) |=> !out_o.cap_pulse)
        else $error("prescaled capture taken too early");

    a_fall_only: assert property (
        (run && rise && (q_r.capture_mode_select == ICAP_M_FALL))
        |=> !out_o.cap_pulse)
        else $error("falling mode captured a rising edge");

    a_edge_both: assert property (
        (run && (rise || fall) && (q_r.capture_mode_select == ICAP_M_EDGE))
        |=> out_o.cap_pulse && out_o.irq)
        else $error("edge mode missed an edge or interrupt");

    a_wake_no_capture: assert property (
        (q_r.capture_mode_select == ICAP_M_WAKE) |=>
        !out_o.cap_pulse && (q_r.level == 3'h0))
        else $error("wake mode stored a capture");

    a_off_flushed: assert property (
        (q_r.capture_mode_select == ICAP_M_OFF) ##1
        (q_r.capture_mode_select == ICAP_M_OFF)
        |-> (q_r.level == 3'h0) && !q_r.buffer_overflow_flag)
        else $error("disabled channel keeps buffered data");

    a_irq_count: assert property (
        (out_o.irq && !out_o.wake_irq &&
         ($past(q_r.capture_mode_select) != ICAP_M_EDGE))
        |-> ($past(q_r.evt) == $past(q_r.captures_per_irq)))
        else $error("interrupt at wrong capture count");

    a_push_level: assert property (
        s_room_cap |=> (q_r.level == $past(q_r.level) + 3'h1) &&
        (q_r.fifo[$past(q_r.wr_ptr)] == $past(q_r.channel_counter)))
        else $error("capture not pushed");

    a_overflow_keep: assert property (
        s_full_cap |=> q_r.buffer_overflow_flag &&
        (q_r.level == ICAP_DEPTH) && (q_r.wr_ptr == $past(q_r.wr_ptr)))
        else $error("full buffer overwritten or overflow missed");

    a_bne_read: assert property (
        (acc && avs_i.read && (avs_i.address == ICAP_OFS_CTRL1))
        |=> (avs_o.readdata[ICAP_B_BNE] == ($past(q_r.level) != 3'h0)))
        else $error("not-empty flag wrong on read");

    a_hold_clear: assert property (
        hold [*2] |-> (q_r.channel_counter == 16'h0000))
        else $error("untriggered counter not held at zero");

    a_idle_halt: assert property (
        (q_r.stop_when_idle && ev_i.cpu_idle) |=> !out_o.cap_pulse)
        else $error("capture while halted in idle");

endmodule

// [verif/icap_pin_model.sv]
// pin model: the measured signal on the capture input.
// assumes the bench calls pulses() from its main sequence only.
`timescale 1ns/10ps

module icap_pin_model (
    // clock
    input wire logic clk_i,
    // measured level
    output logic pin_o
);
    initial pin_o = 1'b0;

    // two cycles high, then low: every edge stays visible to the sampler
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            pin_o <= 1'b0;
            @(posedge clk_i);
        end
    endtask
endmodule

// [verif/input_capture_channel_bench.sv]
// bench for the capture channel: bus tasks, mode table, trigger check.
// assumes the pin model beside it and a 4-bit register address space.
`timescale 1ns/10ps

module input_capture_channel_bench;
    import icap_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    icap_avs_req_t avs = '0;
    icap_avs_rsp_t avs_o;
    icap_out_t out_o;
    icap_evt_t ev;
    logic pin;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    logic [4:0] tick = 5'h00;
    logic [31:0] sync = 32'h0;
    logic [15:0] cnt = 16'h0;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int n_compared = 0;
    int n_irq = 0;
    int n_cap = 0;
    int n_dma = 0;
    int n_wake = 0;
    logic casc = 1'b0;
    logic carry = 1'b0;
    // mode, cpi, pulses, captures, interrupts, flags (1 sleep, 2 idle)
    int md[9] = '{3, 2, 1, 4, 5, 3, 0, 6, 7};
    int cpi[9] = '{1, 0, 3, 0, 0, 0, 0, 0, 0};
    int pn[9] = '{5, 3, 2, 8, 16, 2, 2, 2, 2};
    int nc[9] = '{5, 3, 4, 2, 1, 0, 0, 0, 0};
    int ni[9] = '{2, 3, 4, 2, 1, 0, 0, 0, 2};
    int fl[9] = '{0, 0, 0, 0, 0, 2, 0, 0, 1};
    // timer tick line for counter clock select codes 0 to 4
    int tb[5] = '{2, 1, 3, 4, 0};

    // cascade position and partner wrap come from the cascade scenario
    assign ev = '{capture_pin: pin, cpu_idle: idle, cpu_sleep: sleep,
        tmr_tick: tick, casc_carry: carry, casc_upper: casc};

    icap_channel i_icap_channel (.clk_i(clk_i), .nrst_i(nrst_i),
        .avs_i(avs), .avs_o(avs_o), .ev_i(ev), .sync_evt_i(sync),
        .out_o(out_o));
    icap_pin_model i_icap_pin_model (.clk_i(clk_i), .pin_o(pin));

    initial
    begin
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic r, input logic [3:0] a,
                       input logic [31:0] d);
        int t;
        @(posedge clk_i);
        avs <= '{read: r, write: !r, address: a, writedata: d,
            byteenable: 4'hF};
        t = 0;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (avs_o.waitrequest !== 1'b0 && t < 16);
        avs <= '0;
        if (t >= 16)
        begin
            n_errors++;
            summarize();
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask

    // count enables on the lines in m (bit 5 is the partner wrap)
    task automatic ticks(input int n, input logic [5:0] m);
        repeat (n)
        begin
            @(posedge clk_i);
            {carry, tick} <= m;
            @(posedge clk_i);
            {carry, tick} <= 6'h00;
            cnt++;
        end
    endtask

    // one-cycle events on the trigger or sync source lines
    task automatic fire(input logic [31:0] s);
        @(posedge clk_i);
        sync <= s;
        @(posedge clk_i);
        sync <= 32'h0;
    endtask

    // read answers are taken off the queue at the edge they are sampled
    always @(posedge clk_i)
    begin
        if (out_o.irq === 1'b1)
            n_irq++;
        if (out_o.cap_pulse === 1'b1)
            n_cap++;
        if (out_o.dma_req === 1'b1)
            n_dma++;
        if (out_o.wake_irq === 1'b1)
            n_wake++;
        if (avs.read === 1'b1 && avs_o.waitrequest === 1'b0)
            check(avs_o.readdata, exp_q.pop_front());
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        int k;
        int b_cap;
        int b_dma;
        int b_wake;
        int t;
        logic [15:0] c1;
        k = $urandom(32'hF3137B6C);
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(ICAP_OFS_CTRL1, 32'h0);
        rd(ICAP_OFS_CTRL2, 32'h0000000D);
        rd(4'h2, 32'h0);
        wr(ICAP_OFS_CTRL1, 32'h00000018);
        rd(ICAP_OFS_CTRL1, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            c1 = 16'(md[i] | cpi[i] << ICAP_B_CPI | fl[i][1] << ICAP_B_SIDL
                | (i < 5 ? i : 0) << ICAP_B_TSEL);
            wr(ICAP_OFS_CTRL1, 32'h0);
            cnt = 16'h0;
            wr(ICAP_OFS_CTRL1, {16'h0, c1});
            if (i < 5)
                ticks($urandom_range(9, 1), 6'(1 << tb[i]));
            @(posedge clk_i);
            idle <= fl[i][1];
            sleep <= fl[i][0];
            k = n_irq;
            b_cap = n_cap;
            b_dma = n_dma;
            b_wake = n_wake;
            i_icap_pin_model.pulses(pn[i]);
            repeat (4) @(posedge clk_i);
            idle <= 1'b0;
            sleep <= 1'b0;
            check(n_irq - k, ni[i]);
            check(n_cap - b_cap, nc[i]);
            check(n_dma - b_dma, nc[i]);
            check(n_wake - b_wake, md[i] == 7 ? ni[i] : 0);
            k = nc[i] > 4 ? 4 : nc[i];
            rd(ICAP_OFS_CTRL1, {16'h0, c1} | (nc[i] > 4 ? 32'h10 : 32'h0)
                | (k > 0 ? 32'h8 : 32'h0));
            repeat (k) rd(ICAP_OFS_DATA, {16'h0, cnt});
            rd(ICAP_OFS_DATA, 32'h0);
            rd(ICAP_OFS_CTRL1, {16'h0, c1});
        end
        // a stored capture is dropped when the channel is switched off
        wr(ICAP_OFS_CTRL1, 32'h3);
        i_icap_pin_model.pulses(1);
        wr(ICAP_OFS_CTRL1, 32'h0);
        rd(ICAP_OFS_CTRL1, 32'h0);
        rd(ICAP_OFS_DATA, 32'h0);
        // trigger operation: counter held clear until the source fires
        wr(ICAP_OFS_CTRL1, 32'h3);
        wr(ICAP_OFS_CTRL2, 32'h0000008D);
        ticks(3, 6'h04);
        rd(ICAP_OFS_COUNT, 32'h0);
        fire(32'h0000_2000);
        rd(ICAP_OFS_CTRL2, 32'h000000CD);
        ticks(2, 6'h04);
        rd(ICAP_OFS_COUNT, 32'h2);
        wr(ICAP_OFS_CTRL2, 32'h0000008D);
        rd(ICAP_OFS_COUNT, 32'h0);
        // sync operation: a source event restarts the running counter
        wr(ICAP_OFS_CTRL2, 32'h0000000D);
        ticks(3, 6'h04);
        fire(32'h0000_2000);
        ticks(2, 6'h04);
        rd(ICAP_OFS_COUNT, 32'h2);
        // a no-source code ignores every source line
        wr(ICAP_OFS_CTRL2, 32'h0000001F);
        fire(32'hFFFF_FFFF);
        rd(ICAP_OFS_COUNT, 32'h2);
        // cascade upper half counts the partner's wrap pulses only
        wr(ICAP_OFS_CTRL2, 32'h0000010D);
        wr(ICAP_OFS_CTRL1, 32'h0);
        casc <= 1'b1;
        wr(ICAP_OFS_CTRL1, 32'h3);
        ticks(2, 6'h04);
        ticks(3, 6'h20);
        rd(ICAP_OFS_COUNT, 32'h3);
        // lower half on the peripheral clock wraps after 65536 counts
        casc <= 1'b0;
        wr(ICAP_OFS_CTRL1, 32'h0);
        wr(ICAP_OFS_CTRL1, 32'h1C03);
        t = 0;
        while (out_o.wrap !== 1'b1 && t < 70000)
        begin
            @(posedge clk_i);
            t++;
        end
        check(t, 65537);
        repeat (4) @(posedge clk_i);
        summarize();
    end
endmodule
